//--- shared/pmr_pkg.sv
// Constants for the PHY miscellaneous, coding and frame configuration bank.
// Assumes a 32-bit APB slave; each register index is a word, byte address = 4 x index.
package pmr_pkg;
   // Register indices
   localparam logic [11:0] PMR_IDX_PIN_READBACK_TWO = 12'h458;
   localparam logic [11:0] PMR_IDX_STRAP_CAPTURE    = 12'h45D;
   localparam logic [11:0] PMR_IDX_LED_CLOCK_MUX    = 12'h45F;
   localparam logic [11:0] PMR_IDX_CODING_ONE       = 12'h485;
   localparam logic [11:0] PMR_IDX_CODING_TWO       = 12'h486;
   localparam logic [11:0] PMR_IDX_TX_INTERLEAVE    = 12'h489;
   localparam logic [11:0] PMR_IDX_BABBLE_TIMEOUT   = 12'h496;
   localparam logic [11:0] PMR_IDX_TEST_PATTERN     = 12'h497;
   localparam logic [11:0] PMR_IDX_RX_FRAME         = 12'h4A0;

   // Reset values
   localparam logic [15:0] PMR_RST_LED_CLOCK_MUX = 16'h000C;
   localparam logic [15:0] PMR_RST_CODING_ONE    = 16'h1078;
   localparam logic [15:0] PMR_RST_CODING_TWO    = 16'h0A05;
   localparam logic [15:0] PMR_RST_TX_INTERLEAVE = 16'h0001;
   localparam logic [15:0] PMR_RST_BABBLE        = 16'h044C;
   localparam logic [15:0] PMR_RST_TEST_PATTERN  = 16'h01C0;
   localparam logic [15:0] PMR_RST_RX_FRAME      = 16'h1000;

   // Writable bit masks
   localparam logic [15:0] PMR_WM_LED_CLOCK_MUX = 16'hC01F;
   localparam logic [15:0] PMR_WM_CODING_ONE    = 16'h71FF;
   localparam logic [15:0] PMR_WM_CODING_TWO    = 16'hFF1F;
   localparam logic [15:0] PMR_WM_TX_INTERLEAVE = 16'h0007;
   localparam logic [15:0] PMR_WM_BABBLE        = 16'h07FF;
   localparam logic [15:0] PMR_WM_TEST_PATTERN  = 16'h03F0;
   localparam logic [15:0] PMR_WM_RX_FRAME      = 16'hFFFD;

   // Field positions
   localparam int PMR_F_ANA_SEL       = 4;
   localparam int PMR_F_LED_MUX_LO    = 2;
   localparam int PMR_F_FORCE_STAGE   = 14;
   localparam int PMR_F_DIS_IPG_CHECK = 13;
   localparam int PMR_F_LINK_CONTROL  = 12;
   localparam int PMR_F_FORCE_TX_IL   = 2;
   localparam int PMR_F_TX_IL_EN      = 1;
   localparam int PMR_F_IL_DET_EN     = 0;
   localparam int PMR_F_PAT_CNT_LO    = 4;
   localparam int PMR_F_SWAP_LO       = 14;
   localparam int PMR_F_SFD_SEL       = 13;
   localparam int PMR_F_ENHANCED_RX   = 7;
   localparam int PMR_F_PWR_LED2      = 13;
   localparam int PMR_F_PWR_LINE3     = 12;
   localparam int PMR_F_RST_LINE3     = 8;

   // Output mux codes
   localparam logic [1:0] PMR_MUX_DAISY   = 2'b00;
   localparam logic [1:0] PMR_MUX_TX_TEST = 2'b01;
   localparam logic [1:0] PMR_MUX_ANALOG  = 2'b10;
   localparam logic [1:0] PMR_MUX_DIGITAL = 2'b11;

   // Receive byte ordering codes
   localparam logic [1:0] PMR_ORD_NONE      = 2'b00;
   localparam logic [1:0] PMR_ORD_BITS      = 2'b01;
   localparam logic [1:0] PMR_ORD_NIBBLES   = 2'b10;
   localparam logic [1:0] PMR_ORD_NIB_BITS  = 2'b11;

   // Start-of-frame delimiters
   localparam logic [7:0] PMR_SFD_NORMAL  = 8'hD5;
   localparam logic [7:0] PMR_SFD_SWAPPED = 8'h5D;

   // Timing
   localparam int PMR_CLK_MHZ      = 100;
   localparam int PMR_US_NS        = 1000;
   localparam int PMR_CLK_PERIOD_NS = 1000 / PMR_CLK_MHZ;
   localparam int PMR_US_CYCLES    = PMR_US_NS / PMR_CLK_PERIOD_NS;
endpackage : pmr_pkg

//--- design/pmr_regs.sv
// PHY miscellaneous, coding and receive frame configuration register bank.
// Assumes an APB master on i_ref_clk, synchronous pins, power-on reset on i_por_nrst.
//
// Behaviour
// - Forced-input pins read back live: bit0 receive line one, bit1 line two.
// - LED2 and line-3 straps latch only at power-up into bits 13, 12.
// - Line-3 strap latches into bit 8 at every reset.
// - Other straps latch at power-up and at reset into bits 9, 7-0.
// - Bits 3-2 pick LED2 output: daisy, test clock, analog, digital.
// - LED2 selector resets to 00 if line-3 strap high, else 11.
// - Bits 1-0 pick clock-out source; reset 11 if line-3 strap high, else 00.
// - LED2 strapped as daisy clock forces the digital output path.
// - Bit 4 picks the analog test clock for the test line; resets 0.
// - Bit 14 forces training stage one reported done.
// - Bit 13 suppresses descrambler lock check during inter-packet gaps.
// - Bit 12, reset 1, enables training and link-up; 0 stops start.
// - Lock declared after idle-symbol count in bits 8-0.
// - Lock lost after non-idle count in bits 15-8.
// - Remote receiver status drops after error count in bits 4-0.
// - Bit 2 forces transmit interleaving.
// - Bit 1 interleaves transmit only when receive interleave was detected.
// - Bit 0, reset 1, enables receive interleave detection.
// - Receive jabber timer expires after bits 10-0 microseconds.
// - Test mode 1 sends 2 plus twice bits 9-4 alternating symbols.
// - Bits 15-14 reorder each receive byte: none, bits, nibbles, nibble bits.
// - Delimiter searched is D5 when bit 13 is 0, else 5D.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

module pmr_regs
   import pmr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and resets
   input  wire logic              i_ref_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_por_nrst,
   // APB slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic                   o_pready,
   output logic [31:0]            o_prdata,
   output logic                   o_pslverr,
   // Strap pins
   input  wire logic              i_second_indicator_strap,
   input  wire logic              i_first_indicator_strap,
   input  wire logic              i_receive_line_three,
   input  wire logic              i_receive_line_two,
   input  wire logic              i_receive_line_one,
   input  wire logic              i_receive_line_zero,
   input  wire logic              i_rx_clock_strap,
   input  wire logic [1:0]        i_rx_error_strap,
   input  wire logic [1:0]        i_rx_valid_strap,
   // Pin readback
   input  wire logic [1:0]        i_line_forced_input,
   // Symbol stream
   input  wire logic              i_sym_valid,
   input  wire logic              i_sym_idle,
   input  wire logic              i_sym_error,
   input  wire logic              i_in_ipg,
   // Interleave and jabber
   input  wire logic              i_rx_interleave_seen,
   input  wire logic              i_rx_active,
   // Receive bytes
   input  wire logic              i_rx_byte_valid,
   input  wire logic [7:0]        i_rx_byte,
   // Controls out
   output logic [1:0]             o_led2_mux_sel,
   output logic [1:0]             o_clkout_mux_sel,
   output logic                   o_analog_test_line_select,
   output logic                   o_force_training_stage_done,
   output logic                   o_training_enable,
   output logic                   o_scr_locked,
   output logic                   o_rem_rcvr_ok,
   output logic                   o_interleave_detect_en,
   output logic                   o_tx_interleave,
   output logic                   o_rx_jabber,
   output logic [7:0]             o_pattern_symbol_total,
   output logic                   o_rx_byte_valid,
   output logic [7:0]             o_rx_byte,
   output logic                   o_sfd_match,
   output logic                   o_enhanced_rx_en
);

   function automatic logic [15:0] merge(input logic [15:0] old_v,
                                         input logic [31:0] wd,
                                         input logic [15:0] mask);
      merge = (old_v & ~mask) | (wd[15:0] & mask);
   endfunction : merge

   function automatic logic [7:0] reorder(input logic [7:0] b, input logic [1:0] mode);
      logic [7:0] r;
      r = b;
      case (mode)
         PMR_ORD_BITS:     r = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
         PMR_ORD_NIBBLES:  r = {b[3:0], b[7:4]};
         PMR_ORD_NIB_BITS: r = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
         default:          r = b;
      endcase
      reorder = r;
   endfunction : reorder

   localparam logic [9:0] US_CNT_MAX = 10'(PMR_US_CYCLES - 1);

   logic [15:0] led_mux_q;
   logic [15:0] coding_one_q;
   logic [15:0] coding_two_q;
   logic [15:0] tx_il_q;
   logic [15:0] babble_q;
   logic [15:0] pattern_q;
   logic [15:0] rx_frame_q;
   logic [15:0] strap_q;
   logic [1:0]  pwr_strap_q;
   logic        por_pend_q;
   logic        rst_pend_q;
   logic [11:0] idx;
   logic        wr_go;
   logic        rd_go;
   logic        hit;
   logic [15:0] rd_val;
   logic        daisy_strap;
   logic [8:0]  idle_cnt_q;
   logic [7:0]  bad_cnt_q;
   logic [4:0]  err_cnt_q;
   logic [9:0]  us_div_q;
   logic [10:0] us_cnt_q;

   assign idx         = i_paddr[13:2];
   assign rd_go       = i_psel && i_penable && !o_pready;
   assign wr_go       = i_psel && i_penable && o_pready && i_pwrite && hit;
   assign daisy_strap = pwr_strap_q[1];

   // Address decode and read mux
   always_comb begin
      hit    = 1'b1;
      rd_val = 16'h0000;
      if (idx == PMR_IDX_PIN_READBACK_TWO) begin
         rd_val = {14'h0000, i_receive_line_two & i_line_forced_input[1],
                   i_receive_line_one & i_line_forced_input[0]};
      end else if (idx == PMR_IDX_STRAP_CAPTURE) begin
         rd_val = strap_q | {2'b00, pwr_strap_q, 12'h000};
      end else if (idx == PMR_IDX_LED_CLOCK_MUX) begin
         rd_val = led_mux_q;
      end else if (idx == PMR_IDX_CODING_ONE) begin
         rd_val = coding_one_q;
      end else if (idx == PMR_IDX_CODING_TWO) begin
         rd_val = coding_two_q;
      end else if (idx == PMR_IDX_TX_INTERLEAVE) begin
         rd_val = tx_il_q;
      end else if (idx == PMR_IDX_BABBLE_TIMEOUT) begin
         rd_val = babble_q;
      end else if (idx == PMR_IDX_TEST_PATTERN) begin
         rd_val = pattern_q;
      end else if (idx == PMR_IDX_RX_FRAME) begin
         rd_val = rx_frame_q;
      end else begin
         hit = 1'b0;
      end
   end

   // APB answer: one wait cycle, then ready with data
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (rd_go) begin
         o_pready  <= 1'b1;
         o_prdata  <= i_pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
         o_pslverr <= !hit;
      end else begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   // Capture pending flags, cleared one edge after release
   always_ff @(posedge i_ref_clk or negedge i_por_nrst) begin
      if (!i_por_nrst) begin
         por_pend_q  <= 1'b1;
         pwr_strap_q <= 2'b00;
      end else if (por_pend_q) begin
         por_pend_q  <= 1'b0;
         pwr_strap_q <= {i_second_indicator_strap, i_receive_line_three};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_pend_q <= 1'b1;
         strap_q    <= 16'h0000;
      end else if (rst_pend_q || por_pend_q) begin
         rst_pend_q <= 1'b0;
         strap_q[PMR_F_RST_LINE3] <= i_receive_line_three;
         strap_q[9]   <= i_first_indicator_strap;
         strap_q[7:5] <= {i_receive_line_two, i_receive_line_one, i_receive_line_zero};
         strap_q[4]   <= i_rx_clock_strap;
         strap_q[3:2] <= i_rx_error_strap;
         strap_q[1:0] <= i_rx_valid_strap;
      end
   end

   // Writable registers
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         led_mux_q    <= PMR_RST_LED_CLOCK_MUX;
         coding_one_q <= PMR_RST_CODING_ONE;
         coding_two_q <= PMR_RST_CODING_TWO;
         tx_il_q      <= PMR_RST_TX_INTERLEAVE;
         babble_q     <= PMR_RST_BABBLE;
         pattern_q    <= PMR_RST_TEST_PATTERN;
         rx_frame_q   <= PMR_RST_RX_FRAME;
      end else if (rst_pend_q) begin
         led_mux_q[3:0] <= i_receive_line_three ? {PMR_MUX_DAISY, PMR_MUX_DIGITAL}
                                                : {PMR_MUX_DIGITAL, PMR_MUX_DAISY};
      end else if (wr_go) begin
         if (idx == PMR_IDX_LED_CLOCK_MUX) begin
            led_mux_q <= merge(led_mux_q, i_pwdata, PMR_WM_LED_CLOCK_MUX);
         end else if (idx == PMR_IDX_CODING_ONE) begin
            coding_one_q <= merge(coding_one_q, i_pwdata, PMR_WM_CODING_ONE);
         end else if (idx == PMR_IDX_CODING_TWO) begin
            coding_two_q <= merge(coding_two_q, i_pwdata, PMR_WM_CODING_TWO);
         end else if (idx == PMR_IDX_TX_INTERLEAVE) begin
            tx_il_q <= merge(tx_il_q, i_pwdata, PMR_WM_TX_INTERLEAVE);
         end else if (idx == PMR_IDX_BABBLE_TIMEOUT) begin
            babble_q <= merge(babble_q, i_pwdata, PMR_WM_BABBLE);
         end else if (idx == PMR_IDX_TEST_PATTERN) begin
            pattern_q <= merge(pattern_q, i_pwdata, PMR_WM_TEST_PATTERN);
         end else if (idx == PMR_IDX_RX_FRAME) begin
            rx_frame_q <= merge(rx_frame_q, i_pwdata, PMR_WM_RX_FRAME);
         end
      end
   end

   // Output muxes and static controls
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_led2_mux_sel              <= PMR_MUX_DIGITAL;
         o_clkout_mux_sel            <= PMR_MUX_DAISY;
         o_analog_test_line_select   <= 1'b0;
         o_force_training_stage_done <= 1'b0;
         o_training_enable           <= 1'b0;
         o_interleave_detect_en      <= 1'b0;
         o_tx_interleave             <= 1'b0;
         o_pattern_symbol_total      <= 8'h00;
         o_enhanced_rx_en            <= 1'b0;
      end else begin
         o_led2_mux_sel   <= daisy_strap ? PMR_MUX_DIGITAL
                                         : led_mux_q[PMR_F_LED_MUX_LO +: 2];
         o_clkout_mux_sel <= daisy_strap ? PMR_MUX_DIGITAL : led_mux_q[1:0];
         o_analog_test_line_select   <= led_mux_q[PMR_F_ANA_SEL];
         o_force_training_stage_done <= coding_one_q[PMR_F_FORCE_STAGE];
         o_training_enable           <= coding_one_q[PMR_F_LINK_CONTROL];
         o_interleave_detect_en      <= tx_il_q[PMR_F_IL_DET_EN];
         o_tx_interleave <= tx_il_q[PMR_F_FORCE_TX_IL] ||
                            (tx_il_q[PMR_F_TX_IL_EN] && tx_il_q[PMR_F_IL_DET_EN] &&
                             i_rx_interleave_seen);
         o_pattern_symbol_total <= 8'h02 + {1'b0, pattern_q[PMR_F_PAT_CNT_LO +: 6], 1'b0};
         o_enhanced_rx_en       <= rx_frame_q[PMR_F_ENHANCED_RX];
      end
   end

   // Descrambler lock tracking
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         idle_cnt_q   <= 9'h000;
         bad_cnt_q    <= 8'h00;
         o_scr_locked <= 1'b0;
      end else if (i_sym_valid) begin
         if (!o_scr_locked) begin
            if (!i_sym_idle) begin
               idle_cnt_q <= 9'h000;
            end else if (idle_cnt_q + 9'h001 >= coding_one_q[8:0]) begin
               o_scr_locked <= 1'b1;
               idle_cnt_q   <= 9'h000;
               bad_cnt_q    <= 8'h00;
            end else begin
               idle_cnt_q <= idle_cnt_q + 9'h001;
            end
         end else if (!i_sym_idle && !(coding_one_q[PMR_F_DIS_IPG_CHECK] && i_in_ipg)) begin
            if (bad_cnt_q + 8'h01 >= coding_two_q[15:8]) begin
               o_scr_locked <= 1'b0;
               bad_cnt_q    <= 8'h00;
            end else begin
               bad_cnt_q <= bad_cnt_q + 8'h01;
            end
         end
      end
   end

   // Remote receiver status
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         err_cnt_q     <= 5'h00;
         o_rem_rcvr_ok <= 1'b0;
      end else if (!o_scr_locked) begin
         err_cnt_q <= 5'h00;
      end else if (i_sym_valid && i_sym_error && o_rem_rcvr_ok) begin
         if (err_cnt_q + 5'h01 >= coding_two_q[4:0]) begin
            o_rem_rcvr_ok <= 1'b0;
         end
         err_cnt_q <= err_cnt_q + 5'h01;
      end else if (!o_rem_rcvr_ok && err_cnt_q == 5'h00) begin
         o_rem_rcvr_ok <= 1'b1;
      end
   end

   // Jabber timer in microseconds
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         us_div_q    <= 10'h000;
         us_cnt_q    <= 11'h000;
         o_rx_jabber <= 1'b0;
      end else if (!i_rx_active) begin
         us_div_q    <= 10'h000;
         us_cnt_q    <= 11'h000;
         o_rx_jabber <= 1'b0;
      end else if (us_div_q == US_CNT_MAX) begin
         us_div_q <= 10'h000;
         if (us_cnt_q + 11'h001 >= babble_q[10:0]) begin
            o_rx_jabber <= 1'b1;
         end else begin
            us_cnt_q <= us_cnt_q + 11'h001;
         end
      end else begin
         us_div_q <= us_div_q + 10'h001;
      end
   end

   // Receive byte ordering and delimiter match
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rx_byte_valid <= 1'b0;
         o_rx_byte       <= 8'h00;
         o_sfd_match     <= 1'b0;
      end else begin
         o_rx_byte_valid <= i_rx_byte_valid;
         o_rx_byte <= reorder(i_rx_byte, rx_frame_q[PMR_F_SWAP_LO +: 2]);
         o_sfd_match <= i_rx_byte_valid &&
                        (reorder(i_rx_byte, rx_frame_q[PMR_F_SWAP_LO +: 2]) ==
                         (rx_frame_q[PMR_F_SFD_SEL] ? PMR_SFD_SWAPPED : PMR_SFD_NORMAL));
      end
   end

endmodule : pmr_regs

//--- testbench/pmr_regs_props.sv
// Port checker for the configuration register bank.
// Bound into every pmr_regs instance; sees only its ports.
`timescale 1ns/1ps
module pmr_regs_props
   import pmr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock, reset and APB
   input wire logic              i_ref_clk,
   input wire logic              i_nrst,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic              i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic              o_pready,
   input wire logic [31:0]       o_prdata,
   input wire logic              o_pslverr,
   // Symbol, jabber and byte paths
   input wire logic              i_sym_valid,
   input wire logic              i_sym_idle,
   input wire logic              i_rx_active,
   input wire logic              o_scr_locked,
   input wire logic              o_rx_jabber,
   input wire logic              o_rx_byte_valid,
   input wire logic [7:0]        o_rx_byte,
   input wire logic              o_sfd_match
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_wait;
      i_psel && i_penable && !o_pready;
   endsequence
   sequence s_pulse;
      o_pready ##1 !o_pready;
   endsequence
   a_one_wait_state: assert property (s_wait |=> s_pulse) else $error("bad ready");
   a_err_with_ready: assert property (o_pslverr |-> o_pready) else $error("lone slverr");
   a_upper_zero: assert property (o_pready && !i_pwrite |-> o_prdata[31:16] == 16'h0000)
      else $error("upper half set");
   a_readback_reserved: assert property (o_pready && !i_pwrite
      && i_paddr[13:2] == PMR_IDX_PIN_READBACK_TWO |-> o_prdata[15:2] == 14'h0000)
      else $error("reserved readback");
   a_sfd_value: assert property (o_sfd_match |-> o_rx_byte_valid
      && (o_rx_byte == PMR_SFD_NORMAL || o_rx_byte == PMR_SFD_SWAPPED)) else $error("bad sfd");
   a_jabber_needs_rx: assert property (!i_rx_active |=> !o_rx_jabber) else $error("jabber");
   a_lock_on_idle: assert property ($rose(o_scr_locked) |-> $past(i_sym_valid)
      && $past(i_sym_idle)) else $error("lock without idle");
   a_unlock_on_busy: assert property ($fell(o_scr_locked) |-> $past(i_sym_valid)
      && !$past(i_sym_idle)) else $error("unlock without symbol");
endmodule : pmr_regs_props

bind pmr_regs pmr_regs_props #(.ADDR_W(ADDR_W)) u_props (.i_ref_clk, .i_nrst, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .o_pready, .o_prdata, .o_pslverr, .i_sym_valid, .i_sym_idle,
   .i_rx_active, .o_scr_locked, .o_rx_jabber, .o_rx_byte_valid, .o_rx_byte, .o_sfd_match);

//--- testbench/tb_pmr_regs.sv
// Self-checking bench for the configuration register bank.
// Drives APB, straps and receive inputs itself; the checker is bound in.
`timescale 1ns/1ps
module tb_pmr_regs
   import pmr_pkg::*;
;
   logic i_ref_clk = 1'h0, i_nrst = 1'h0, i_por_nrst = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
   logic i_pwrite = 1'h0, i_second_indicator_strap = 1'h0, i_first_indicator_strap = 1'h0;
   logic i_receive_line_three = 1'h0, i_receive_line_two = 1'h0, i_receive_line_one = 1'h0;
   logic i_receive_line_zero = 1'h0, i_rx_clock_strap = 1'h0, i_sym_valid = 1'h0;
   logic i_sym_idle = 1'h0, i_sym_error = 1'h0, i_in_ipg = 1'h0, i_rx_interleave_seen = 1'h0;
   logic i_rx_active = 1'h0, i_rx_byte_valid = 1'h0, pre;
   logic [1:0] i_rx_error_strap = 2'h0, i_rx_valid_strap = 2'h0, i_line_forced_input = 2'h0, pwr;
   logic [15:0] i_paddr = 16'h0000, cap;
   logic [31:0] i_pwdata = 32'h0000_0000, o_prdata;
   logic [7:0] i_rx_byte = 8'h00, o_pattern_symbol_total, o_rx_byte;
   logic [1:0] o_led2_mux_sel, o_clkout_mux_sel;
   logic o_pready, o_pslverr, o_analog_test_line_select, o_force_training_stage_done;
   logic o_training_enable, o_scr_locked, o_rem_rcvr_ok, o_interleave_detect_en;
   logic o_tx_interleave, o_rx_jabber, o_rx_byte_valid, o_sfd_match, o_enhanced_rx_en;
   logic [32:0] rq[$];
   logic [8:0] bq[$];
   int miscompares = 0, n_compared = 0;
   logic [11:0] idx [7] = '{PMR_IDX_CODING_ONE, PMR_IDX_CODING_TWO, PMR_IDX_TX_INTERLEAVE,
      PMR_IDX_BABBLE_TIMEOUT, PMR_IDX_TEST_PATTERN, PMR_IDX_RX_FRAME, PMR_IDX_LED_CLOCK_MUX};
   logic [15:0] rst [7] = '{PMR_RST_CODING_ONE, PMR_RST_CODING_TWO, PMR_RST_TX_INTERLEAVE,
      PMR_RST_BABBLE, PMR_RST_TEST_PATTERN, PMR_RST_RX_FRAME, 16'h0003};
   logic [15:0] wm [7] = '{PMR_WM_CODING_ONE, PMR_WM_CODING_TWO, PMR_WM_TX_INTERLEAVE,
      PMR_WM_BABBLE, PMR_WM_TEST_PATTERN, PMR_WM_RX_FRAME, PMR_WM_LED_CLOCK_MUX};

   pmr_regs uut (.*);

   initial forever #5 i_ref_clk = ~i_ref_clk;

   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results

   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_psel   <= 1'h1;
      i_pwrite <= w;
      i_paddr  <= {2'h0, a, 2'h0};
      i_pwdata <= {16'h0000, d};
      @(posedge i_ref_clk);
      i_penable <= 1'h1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'h1 && n < 20);
      if (n >= 20) begin
         chk(33'(n), 33'h0);
         results();
      end
      i_psel    <= 1'h0;
      i_penable <= 1'h0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic err);
      rq.push_back({err, 16'h0000, e});
      apb(1'h0, a, 16'h0000);
   endtask : rd

   task automatic settle();
      repeat (2) @(posedge i_ref_clk);
      #1;
   endtask : settle

   task automatic do_rst(input logic p, input logic l3, input logic sec);
      @(posedge i_ref_clk);
      {i_first_indicator_strap, i_receive_line_two, i_receive_line_one, i_receive_line_zero,
         i_rx_clock_strap, i_rx_error_strap, i_rx_valid_strap} <= 9'($urandom);
      i_receive_line_three     <= l3;
      i_second_indicator_strap <= sec;
      i_nrst                   <= 1'h0;
      i_por_nrst               <= !p;
      repeat (4) @(posedge i_ref_clk);
      i_nrst     <= 1'h1;
      i_por_nrst <= 1'h1;
      repeat (3) @(posedge i_ref_clk);
      if (p) pwr = {sec, l3};
      cap = {2'h0, pwr, 2'h0, i_first_indicator_strap, l3, i_receive_line_two,
         i_receive_line_one, i_receive_line_zero, i_rx_clock_strap, i_rx_error_strap,
         i_rx_valid_strap};
   endtask : do_rst

   // Pre holds lock state before the last symbol
   task automatic sym(input logic idle, input logic err, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_ref_clk);
         i_sym_valid <= 1'h1;
         i_sym_idle  <= idle;
         i_sym_error <= err;
      end
      @(posedge i_ref_clk);
      pre = o_scr_locked;
      i_sym_valid <= 1'h0;
      #1;
   endtask : sym

   function automatic logic [7:0] ordr(input logic [1:0] m, input logic [7:0] b);
      case (m)
         2'h0: return b;
         2'h1: return {<<{b}};
         2'h2: return {b[3:0], b[7:4]};
         default: return {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      endcase
   endfunction : ordr

   always @(posedge i_ref_clk) begin
      if (i_psel && i_penable && o_pready === 1'h1 && !i_pwrite) begin
         if (rq.size() == 0) chk(33'h1, 33'h0);
         else chk({o_pslverr, o_prdata}, rq.pop_front());
      end
      if (o_rx_byte_valid === 1'h1) begin
         if (bq.size() == 0) chk(33'h1, 33'h0);
         else chk({o_sfd_match, o_rx_byte}, bq.pop_front());
      end
   end

   initial begin
      logic [1:0] r;
      logic [7:0] s, b, e;
      void'($urandom(75));
      do_rst(1'h1, 1'h1, 1'h0);
      rd(PMR_IDX_STRAP_CAPTURE, cap, 1'h0);
      settle();
      chk({o_led2_mux_sel, o_clkout_mux_sel}, {PMR_MUX_DAISY, PMR_MUX_DIGITAL});
      chk(o_pattern_symbol_total, 8'h3A);
      for (int k = 0; k < 7; k++) begin
         rd(idx[k], rst[k], 1'h0);
         apb(1'h1, idx[k], 16'hFFFF);
         rd(idx[k], wm[k], 1'h0);
         apb(1'h1, idx[k], rst[k]);
      end
      apb(1'h1, PMR_IDX_STRAP_CAPTURE, 16'hFFFF);
      rd(PMR_IDX_STRAP_CAPTURE, cap, 1'h0);
      apb(1'h1, 12'h100, 16'hFFFF);
      rd(12'h100, 16'h0000, 1'h1);
      for (int k = 0; k < 4; k++) begin
         r = 2'($urandom);
         {i_receive_line_two, i_receive_line_one} <= r;
         i_line_forced_input <= k[1:0];
         rd(PMR_IDX_PIN_READBACK_TWO, {14'h0000, r & k[1:0]}, 1'h0);
      end
      for (int k = 0; k < 4; k++) begin
         apb(1'h1, PMR_IDX_LED_CLOCK_MUX, {11'h000, k[0], k[1:0], ~k[1:0]});
         settle();
         chk({o_led2_mux_sel, o_clkout_mux_sel}, {k[1:0], ~k[1:0]});
         chk(o_analog_test_line_select, k[0]);
      end
      for (int k = 0; k < 8; k++) begin
         apb(1'h1, PMR_IDX_TX_INTERLEAVE, 16'(k));
         i_rx_interleave_seen <= 1'($urandom);
         settle();
         chk(o_tx_interleave, k[2] | (k[1] & k[0] & i_rx_interleave_seen));
         chk(o_interleave_detect_en, k[0]);
      end
      apb(1'h1, PMR_IDX_CODING_ONE, 16'h6003);
      settle();
      chk({o_force_training_stage_done, o_training_enable}, 2'h2);
      apb(1'h1, PMR_IDX_CODING_ONE, 16'h1003);
      apb(1'h1, PMR_IDX_CODING_TWO, 16'h0502);
      settle();
      chk({o_force_training_stage_done, o_training_enable}, 2'h1);
      sym(1'h1, 1'h0, 3);
      chk({pre, o_scr_locked}, 2'h1);
      sym(1'h0, 1'h0, 5);
      chk({pre, o_scr_locked}, 2'h2);
      sym(1'h1, 1'h0, 3);
      settle();
      chk(o_rem_rcvr_ok, 1'h1);
      sym(1'h0, 1'h1, 2);
      chk(o_rem_rcvr_ok, 1'h0);
      apb(1'h1, PMR_IDX_CODING_ONE, 16'h3003);
      i_in_ipg <= 1'h1;
      sym(1'h1, 1'h0, 3);
      sym(1'h0, 1'h0, 6);
      chk(o_scr_locked, 1'h1);
      apb(1'h1, PMR_IDX_BABBLE_TIMEOUT, 16'h0002);
      i_in_ipg    <= 1'h0;
      i_rx_active <= 1'h1;
      repeat (190) @(posedge i_ref_clk);
      chk(o_rx_jabber, 1'h0);
      repeat (25) @(posedge i_ref_clk);
      chk(o_rx_jabber, 1'h1);
      i_rx_active <= 1'h0;
      apb(1'h1, PMR_IDX_TEST_PATTERN, 16'h03F0);
      settle();
      chk(o_pattern_symbol_total, 8'h80);
      for (int k = 0; k < 8; k++) begin
         apb(1'h1, PMR_IDX_RX_FRAME, {k[2:1], k[0], 13'h1080});
         settle();
         chk(o_enhanced_rx_en, 1'h1);
         s = k[0] ? PMR_SFD_SWAPPED : PMR_SFD_NORMAL;
         for (int j = 0; j < 3; j++) begin
            b = (j == 0) ? ordr(k[2:1], s) : 8'($urandom);
            e = ordr(k[2:1], b);
            bq.push_back({e == s, e});
            @(posedge i_ref_clk);
            i_rx_byte_valid <= 1'h1;
            i_rx_byte       <= b;
         end
         @(posedge i_ref_clk);
         i_rx_byte_valid <= 1'h0;
      end
      do_rst(1'h0, 1'h0, 1'h1);
      rd(PMR_IDX_STRAP_CAPTURE, cap, 1'h0);
      rd(PMR_IDX_LED_CLOCK_MUX, PMR_RST_LED_CLOCK_MUX, 1'h0);
      do_rst(1'h1, 1'h1, 1'h1);
      rd(PMR_IDX_LED_CLOCK_MUX, 16'h0003, 1'h0);
      settle();
      chk({o_led2_mux_sel, o_clkout_mux_sel}, 4'hF);
      results();
   end
endmodule : tb_pmr_regs
